// ### design/line_mux_defs.svh
// offsets, field positions, reset values and timing counts of the line mux
// assumes inclusion by bare name from every file that needs them
`ifndef LINE_MUX_DEFS_SVH
`define LINE_MUX_DEFS_SVH

// ----------------------------------------------------------------
// clock and time unit
// ----------------------------------------------------------------
`define CLK_FREQ_HZ      10000000
`define UNIT_BASE_NS     1000
// least time, so round up to whole cycles
`define UNIT_BASE_CYCLES ((`UNIT_BASE_NS * (`CLK_FREQ_HZ / 1000000) + 999) / 1000)
`define UNIT_X1          1
`define UNIT_X10         10
`define UNIT_X100        100
`define UNIT_X1000       1000

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_LINE_PICK    8'h00
`define OFS_LINE_CFG     8'h04
`define OFS_LINE_STATUS  8'h08
`define OFS_PULSE_CTRL   8'h0c
`define OFS_PULSE_HIGH   8'h10
`define OFS_PULSE_REPEAT 8'h14
`define OFS_BURST_LEN    8'h18
`define OFS_PULSE_STATUS 8'h1c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CFG_INVERT_BIT   0
`define CFG_SOURCE_LSB   4
`define STAT_LEVEL_BIT   0
`define STAT_DIR_BIT     1
`define STAT_KIND_LSB    4
`define CTRL_RUN_BIT     0
`define CTRL_STYLE_BIT   1
`define CTRL_UNIT_LSB    4
`define PST_RUNNING_BIT  0
`define PST_DONE_BIT     1
`define PST_LEVEL_BIT    2
`define SRC_CODE_MAX     4'h9

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PICK_RST         2'h0
`define SOURCE_RST       4'h0
`define INVERT_RST       4'h0
`define UNIT_RST         2'h0
`define HIGH_RST         32'h000003e8
`define REPEAT_RST       32'h0000c350
`define BURST_RST        17'h00001

`endif

// ### design/line_mux_pkg.sv
// types shared by the line mux and its pulse generator
// assumes nothing of its surroundings
package line_mux_pkg;

	// ----------------------------------------------------------------
	// output source codes
	// ----------------------------------------------------------------
	typedef enum logic [3:0]
	{
		SRC_OFF      = 4'h0,
		SRC_BEGIN    = 4'h1,
		SRC_FINISH   = 4'h2,
		SRC_MIDPOINT = 4'h3,
		SRC_WINDOW   = 4'h4,
		SRC_PASS     = 4'h5,
		SRC_LATE     = 4'h6,
		SRC_PULSE    = 4'h7,
		SRC_STROBE_ONE  = 4'h8,
		SRC_STROBE_TWO  = 4'h9
	} source_e;

	// line pick codes
	typedef enum logic [1:0]
	{
		LINE_IN_ONE  = 2'h0,
		LINE_IN_TWO  = 2'h1,
		LINE_OUT_ONE = 2'h2,
		LINE_OUT_TWO = 2'h3
	} line_e;

	// electrical kind codes
	typedef enum logic [1:0]
	{
		KIND_NO_CONNECT = 2'h0,
		KIND_UNDRIVEN   = 2'h1,
		KIND_TTL        = 2'h2,
		KIND_OPTO       = 2'h3
	} kind_e;

	// pulse generator states
	typedef enum logic [1:0]
	{
		GEN_IDLE = 2'h0,
		GEN_RUN  = 2'h1,
		GEN_DONE = 2'h2
	} gen_state_e;

endpackage : line_mux_pkg

// ### design/pulse_train_gen.sv
// programmable pulse train: width and period in selectable time units
// assumes static settings while running, one clock pclk
`timescale 1ns/1ps
`include "line_mux_defs.svh"
module pulse_train_gen
#(
	parameter int CNT_W       = 32,
	parameter int BURST_W     = 17,
	parameter int BASE_CYCLES = `UNIT_BASE_CYCLES
)
(
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               run_on,
	input  wire logic               run_style,
	input  wire logic [1:0]         unit_sel,
	input  wire logic [CNT_W-1:0]   high_count,
	input  wire logic [CNT_W-1:0]   repeat_count,
	input  wire logic [BURST_W-1:0] burst_length,
	output logic                    pulse_out,
	output logic                    running,
	output logic                    burst_done
);
	localparam int PRE_W = $clog2(BASE_CYCLES * `UNIT_X1000) + 1;

	line_mux_pkg::gen_state_e state_reg, state_next;  // run state
	logic [PRE_W-1:0]   pre_reg, pre_next;            // unit prescaler
	logic [CNT_W-1:0]   phase_reg, phase_next;        // units into period
	logic [BURST_W-1:0] num_reg, num_next;            // pulses finished
	logic               out_reg, out_next;            // waveform
	logic [PRE_W-1:0]   unit_cycles;                  // cycles per unit
	logic               tick;                         // one unit elapsed
	logic [CNT_W-1:0]   phase_inc;
	logic [BURST_W-1:0] num_inc;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		unique case (unit_sel)
			2'h0: unit_cycles = PRE_W'(BASE_CYCLES * `UNIT_X1);
			2'h1: unit_cycles = PRE_W'(BASE_CYCLES * `UNIT_X10);
			2'h2: unit_cycles = PRE_W'(BASE_CYCLES * `UNIT_X100);
			2'h3: unit_cycles = PRE_W'(BASE_CYCLES * `UNIT_X1000);
		endcase
		tick       = (pre_reg >= unit_cycles - PRE_W'(1));
		phase_inc  = phase_reg + CNT_W'(1);
		num_inc    = num_reg + BURST_W'(1);
		state_next = state_reg;
		pre_next   = pre_reg;
		phase_next = phase_reg;
		num_next   = num_reg;
		unique case (state_reg)
			line_mux_pkg::GEN_IDLE:
			begin
				// counters wait at zero so a new enable starts clean
				pre_next   = '0;
				phase_next = '0;
				num_next   = '0;
				if (run_on)
					state_next = line_mux_pkg::GEN_RUN;
			end
			line_mux_pkg::GEN_RUN:
			begin
				if (!run_on)
				begin
					state_next = line_mux_pkg::GEN_IDLE;
					pre_next   = '0;
					phase_next = '0;
					num_next   = '0;
				end
				else if (tick)
				begin
					pre_next = '0;
					// period of zero units behaves as one unit
					if (phase_inc >= repeat_count)
					begin
						phase_next = '0;
						num_next   = num_inc;
						// burst length zero is taken as one
						if (run_style && num_inc >= burst_length)
							state_next = line_mux_pkg::GEN_DONE;
					end
					else
						phase_next = phase_inc;
				end
				else
					pre_next = pre_reg + PRE_W'(1);
			end
			line_mux_pkg::GEN_DONE:
			begin
				// stays quiet until software drops the enable
				if (!run_on)
					state_next = line_mux_pkg::GEN_IDLE;
			end
			default:
				state_next = line_mux_pkg::GEN_IDLE;
		endcase
		// high while the phase is under the width count
		out_next = (state_next == line_mux_pkg::GEN_RUN) && (phase_next < high_count);
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= line_mux_pkg::GEN_IDLE;
			pre_reg   <= '0;
			phase_reg <= '0;
			num_reg   <= '0;
			out_reg   <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			pre_reg   <= pre_next;
			phase_reg <= phase_next;
			num_reg   <= num_next;
			out_reg   <= out_next;
		end
	end

	assign pulse_out  = out_reg;
	assign running    = (state_reg == line_mux_pkg::GEN_RUN);
	assign burst_done = (state_reg == line_mux_pkg::GEN_DONE);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_idle_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		!run_on |=> (!pulse_out && !running))
		else $error("pulse output active while disabled");
	a_restart_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == line_mux_pkg::GEN_IDLE && run_on) |=>
		(running && phase_reg == '0 && num_reg == '0 && pre_reg == '0))
		else $error("restart did not clear counters");
	a_burst_rest: assert property (@(posedge pclk) disable iff (!presetn)
		burst_done |-> (!pulse_out && (!$rose(burst_done) ||
		($past(run_style) && num_reg >= $past(burst_length)))))
		else $error("burst ended early or output not resting");

endmodule : pulse_train_gen

// ### design/output_line_mux_pulse_gen.sv
// output line source mux, line inversion and readback, pulse generator
// assumes an APB master on pclk and timing inputs synchronous to pclk
`timescale 1ns/1ps
`include "line_mux_defs.svh"
module output_line_mux_pulse_gen
#(
	parameter int ADDR_W      = 8,
	parameter int CNT_W       = 32,
	parameter int BURST_W     = 17,
	parameter int EXP_W       = 24,
	parameter int BASE_CYCLES = `UNIT_BASE_CYCLES
)
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// timing sources
	input  wire logic              exposure_window_level,
	input  wire logic [EXP_W-1:0]  exposure_length_cycles,
	input  wire logic              trigger_passthrough,
	input  wire logic              trigger_late_copy,
	input  wire logic              strobe_one,
	input  wire logic              strobe_two,
	// lines
	input  wire logic              in_line_one,
	input  wire logic              in_line_two,
	input  wire logic [7:0]        line_electrical_kind,
	output logic                   in_line_one_level,
	output logic                   in_line_two_level,
	output logic                   out_line_one,
	output logic                   out_line_one_oe,
	output logic                   out_line_two,
	output logic                   out_line_two_oe,
	output logic                   pulse_trigger
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [1:0]         pick_reg, pick_next;          // line pick
	logic [3:0]         invert_reg, invert_next;      // per line inversion
	logic [3:0]         source_reg [2];               // per output source
	logic [3:0]         source_next [2];
	logic               run_reg, run_next;            // pulse run on
	logic               style_reg, style_next;        // pulse run style
	logic [1:0]         unit_reg, unit_next;          // pulse time unit
	logic [CNT_W-1:0]   high_reg, high_next;          // pulse high count
	logic [CNT_W-1:0]   repeat_reg, repeat_next;      // pulse repeat count
	logic [BURST_W-1:0] burst_reg, burst_next;        // burst length
	logic [31:0]        prdata_reg, prdata_next;      // read data
	logic               pslverr_reg, pslverr_next;    // unmapped flag
	logic               expo_d_reg;                   // previous exposure level
	logic [EXP_W-1:0]   expo_cnt_reg, expo_cnt_next;  // cycles into exposure
	logic [1:0]         out_reg, oe_reg, in_lvl_reg;  // line flops
	logic [1:0]         out_next, oe_next;
	logic [1:0]         in_lvl_next;
	logic [9:0]         src_vec;                      // candidates by code
	logic               exposure_begin_pulse;
	logic               exposure_finish_pulse;
	logic               exposure_midpoint_pulse;
	logic               gen_out, gen_running, gen_done;
	logic               setup_phase, wr_access, mapped;
	logic [3:0]         line_levels;

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	// zero wait: read data is captured in the setup cycle
	assign setup_phase = psel && !penable;
	assign wr_access   = psel && penable && pwrite;
	assign pready      = 1'b1;
	assign line_levels = {out_reg, in_line_two, in_line_one};

	always_comb
	begin
		unique case (paddr)
			`OFS_LINE_PICK, `OFS_LINE_CFG, `OFS_LINE_STATUS, `OFS_PULSE_CTRL,
			`OFS_PULSE_HIGH, `OFS_PULSE_REPEAT, `OFS_BURST_LEN, `OFS_PULSE_STATUS:
				mapped = 1'b1;
			default:
				mapped = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// register file next values
	// ----------------------------------------------------------------
	always_comb
	begin
		pick_next      = pick_reg;
		invert_next    = invert_reg;
		source_next[0] = source_reg[0];
		source_next[1] = source_reg[1];
		run_next       = run_reg;
		style_next     = style_reg;
		unit_next      = unit_reg;
		high_next      = high_reg;
		repeat_next    = repeat_reg;
		burst_next     = burst_reg;
		prdata_next    = prdata_reg;
		pslverr_next   = pslverr_reg;
		if (wr_access)
		begin
			unique case (paddr)
				`OFS_LINE_PICK:
					pick_next = pwdata[1:0];
				`OFS_LINE_CFG:
				begin
					invert_next[pick_reg] = pwdata[`CFG_INVERT_BIT];
					// inputs have no source; the field is dropped
					if (pick_reg[1])
						source_next[pick_reg[0]] = pwdata[`CFG_SOURCE_LSB +: 4];
				end
				`OFS_PULSE_CTRL:
				begin
					run_next   = pwdata[`CTRL_RUN_BIT];
					style_next = pwdata[`CTRL_STYLE_BIT];
					unit_next  = pwdata[`CTRL_UNIT_LSB +: 2];
				end
				`OFS_PULSE_HIGH:
					high_next = pwdata[CNT_W-1:0];
				`OFS_PULSE_REPEAT:
					repeat_next = pwdata[CNT_W-1:0];
				`OFS_BURST_LEN:
					burst_next = pwdata[BURST_W-1:0];
				default:
					pick_next = pick_reg;  // read only or unmapped
			endcase
		end
		if (setup_phase)
		begin
			pslverr_next = !mapped;
			prdata_next  = '0;
			unique case (paddr)
				`OFS_LINE_PICK:
					prdata_next[1:0] = pick_reg;
				`OFS_LINE_CFG:
				begin
					prdata_next[`CFG_INVERT_BIT] = invert_reg[pick_reg];
					if (pick_reg[1])
						prdata_next[`CFG_SOURCE_LSB +: 4] = source_reg[pick_reg[0]];
				end
				`OFS_LINE_STATUS:
				begin
					prdata_next[`STAT_LEVEL_BIT] = line_levels[pick_reg];
					prdata_next[`STAT_DIR_BIT]   = pick_reg[1];
					prdata_next[`STAT_KIND_LSB +: 2] = line_electrical_kind[{pick_reg, 1'b0} +: 2];
				end
				`OFS_PULSE_CTRL:
				begin
					prdata_next[`CTRL_RUN_BIT]       = run_reg;
					prdata_next[`CTRL_STYLE_BIT]     = style_reg;
					prdata_next[`CTRL_UNIT_LSB +: 2] = unit_reg;
				end
				`OFS_PULSE_HIGH:
					prdata_next[CNT_W-1:0] = high_reg;
				`OFS_PULSE_REPEAT:
					prdata_next[CNT_W-1:0] = repeat_reg;
				`OFS_BURST_LEN:
					prdata_next[BURST_W-1:0] = burst_reg;
				`OFS_PULSE_STATUS:
				begin
					prdata_next[`PST_RUNNING_BIT] = gen_running;
					prdata_next[`PST_DONE_BIT]    = gen_done;
					prdata_next[`PST_LEVEL_BIT]   = gen_out;
				end
				default:
					prdata_next = '0;  // unmapped reads zero
			endcase
		end
	end

	// register file flops
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pick_reg      <= `PICK_RST;
			invert_reg    <= `INVERT_RST;
			source_reg[0] <= `SOURCE_RST;
			source_reg[1] <= `SOURCE_RST;
			run_reg       <= 1'b0;
			style_reg     <= 1'b0;
			unit_reg      <= `UNIT_RST;
			high_reg      <= `HIGH_RST;
			repeat_reg    <= `REPEAT_RST;
			burst_reg     <= `BURST_RST;
			prdata_reg    <= '0;
			pslverr_reg   <= 1'b0;
		end
		else
		begin
			pick_reg      <= pick_next;
			invert_reg    <= invert_next;
			source_reg[0] <= source_next[0];
			source_reg[1] <= source_next[1];
			run_reg       <= run_next;
			style_reg     <= style_next;
			unit_reg      <= unit_next;
			high_reg      <= high_next;
			repeat_reg    <= repeat_next;
			burst_reg     <= burst_next;
			prdata_reg    <= prdata_next;
			pslverr_reg   <= pslverr_next;
		end
	end

	assign prdata  = prdata_reg;
	assign pslverr = pslverr_reg && psel && penable;

	// ----------------------------------------------------------------
	// exposure events
	// ----------------------------------------------------------------
	// midpoint uses the configured length since the end is not known yet
	assign exposure_begin_pulse    = exposure_window_level && !expo_d_reg;
	assign exposure_finish_pulse   = !exposure_window_level && expo_d_reg;
	assign exposure_midpoint_pulse = exposure_window_level &&
		(expo_cnt_reg == (exposure_length_cycles >> 1));

	always_comb
	begin
		expo_cnt_next = exposure_window_level ? expo_cnt_reg + EXP_W'(1) : '0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			expo_d_reg   <= 1'b0;
			expo_cnt_reg <= '0;
		end
		else
		begin
			expo_d_reg   <= exposure_window_level;
			expo_cnt_reg <= expo_cnt_next;
		end
	end

	// ----------------------------------------------------------------
	// pulse generator
	// ----------------------------------------------------------------
	pulse_train_gen
	#(
		.CNT_W       (CNT_W),
		.BURST_W     (BURST_W),
		.BASE_CYCLES (BASE_CYCLES)
	)
	u_gen
	(
		.pclk         (pclk),
		.presetn      (presetn),
		.run_on       (run_reg),
		.run_style    (style_reg),
		.unit_sel     (unit_reg),
		.high_count   (high_reg),
		.repeat_count (repeat_reg),
		.burst_length (burst_reg),
		.pulse_out    (gen_out),
		.running      (gen_running),
		.burst_done   (gen_done)
	);

	// internal trigger use of the generator
	assign pulse_trigger = gen_out;

	// ----------------------------------------------------------------
	// source mux and line flops
	// ----------------------------------------------------------------
	// candidates indexed by source code
	assign src_vec[line_mux_pkg::SRC_OFF]      = 1'b0;
	assign src_vec[line_mux_pkg::SRC_BEGIN]    = exposure_begin_pulse;
	assign src_vec[line_mux_pkg::SRC_FINISH]   = exposure_finish_pulse;
	assign src_vec[line_mux_pkg::SRC_MIDPOINT] = exposure_midpoint_pulse;
	assign src_vec[line_mux_pkg::SRC_WINDOW]   = exposure_window_level;
	assign src_vec[line_mux_pkg::SRC_PASS]     = trigger_passthrough;
	assign src_vec[line_mux_pkg::SRC_LATE]     = trigger_late_copy;
	assign src_vec[line_mux_pkg::SRC_PULSE]    = gen_out;
	assign src_vec[line_mux_pkg::SRC_STROBE_ONE]  = strobe_one;
	assign src_vec[line_mux_pkg::SRC_STROBE_TWO]  = strobe_two;

	// one flop stage on every source keeps the outputs glitch free
	for (genvar g = 0; g < 2; g++)
	begin : g_out
		// codes above nine act as off
		assign out_next[g] = ((source_reg[g] <= `SRC_CODE_MAX) ? src_vec[source_reg[g]] : 1'b0)
			^ invert_reg[g + 2];
		assign oe_next[g]  = (line_electrical_kind[2*(g + 2) +: 2] != line_mux_pkg::KIND_UNDRIVEN);
		assign in_lvl_next[g] = line_levels[g] ^ invert_reg[g];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			out_reg    <= 2'h0;
			oe_reg     <= 2'h0;
			in_lvl_reg <= 2'h0;
		end
		else
		begin
			out_reg    <= out_next;
			oe_reg     <= oe_next;
			in_lvl_reg <= in_lvl_next;
		end
	end

	assign out_line_one      = out_reg[0];
	assign out_line_two      = out_reg[1];
	assign out_line_one_oe   = oe_reg[0];
	assign out_line_two_oe   = oe_reg[1];
	assign in_line_one_level = in_lvl_reg[0];
	assign in_line_two_level = in_lvl_reg[1];

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_off_line_rest: assert property (@(posedge pclk) disable iff (!presetn)
		(source_reg[0] == line_mux_pkg::SRC_OFF) |=> (out_line_one == $past(invert_reg[2])))
		else $error("off line not at rest level");
	a_begin_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		(source_reg[0] == line_mux_pkg::SRC_BEGIN && $rose(exposure_window_level))
		|=> (out_line_one != $past(invert_reg[2])))
		else $error("no pulse at exposure begin");
	a_finish_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		(source_reg[1] == line_mux_pkg::SRC_FINISH && $fell(exposure_window_level))
		|=> (out_line_two != $past(invert_reg[3])))
		else $error("no pulse at exposure finish");
	a_window_level: assert property (@(posedge pclk) disable iff (!presetn)
		(source_reg[0] == line_mux_pkg::SRC_WINDOW)
		|=> (out_line_one == ($past(exposure_window_level) ^ $past(invert_reg[2]))))
		else $error("line does not follow exposure window");
	a_trig_pass: assert property (@(posedge pclk) disable iff (!presetn)
		(source_reg[1] == line_mux_pkg::SRC_PASS)
		|=> (out_line_two == ($past(trigger_passthrough) ^ $past(invert_reg[3]))))
		else $error("trigger not copied");
	a_trig_late: assert property (@(posedge pclk) disable iff (!presetn)
		(source_reg[0] == line_mux_pkg::SRC_LATE && !invert_reg[2])
		|=> (out_line_one == $past(trigger_late_copy)))
		else $error("delayed trigger not copied");
	a_pulse_route: assert property (@(posedge pclk) disable iff (!presetn)
		(source_reg[1] == line_mux_pkg::SRC_PULSE && !invert_reg[3])
		|=> (out_line_two == $past(gen_out)))
		else $error("pulse generator not routed");
	a_undriven_oe: assert property (@(posedge pclk) disable iff (!presetn)
		(line_electrical_kind[7:6] == line_mux_pkg::KIND_UNDRIVEN) |=> !out_line_two_oe)
		else $error("undriven line is driven");

endmodule : output_line_mux_pulse_gen

// ### verification/line_far_side.sv
// far side model: exposure, trigger and strobe equipment
// assumes the bench sets lvl just after a rising pclk edge
`timescale 1ns/1ps
module line_far_side
(
	input  wire logic       pclk,
	input  wire logic [4:0] lvl,
	output logic            win,
	output logic            pass,
	output logic            late,
	output logic            s1,
	output logic            s2
);
	// ----------------------------------------------------------------
	// equipment levels
	// ----------------------------------------------------------------
	// registered so every level moves just after an edge, never mid-cycle
	always_ff @(posedge pclk)
	begin
		{s2, s1, late, pass, win} <= lvl;
	end
endmodule : line_far_side

// ### verification/output_line_mux_pulse_gen_test.sv
// bench: apb tasks, source mux, inversion, readback, pulse generator
// assumes the far side model and a design built with BASE_CYCLES of 1
`timescale 1ns/1ps
module output_line_mux_pulse_gen_test;
	logic        pclk, presetn, psel, penable, pwrite, in1, perr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, o1, o2, oe1, oe2, ptrig, lv1, lv2;
	logic [4:0]  lvl;
	logic        win, pass, late, s1, s2;
	int          err_count, check_count, c, n;
	logic [3:0]  codes [5] = '{4'h4, 4'h5, 4'h6, 4'h8, 4'h9}; // level sources
	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	line_far_side u_line_far_side (.pclk(pclk), .lvl(lvl), .win(win), .pass(pass),
		.late(late), .s1(s1), .s2(s2));
	output_line_mux_pulse_gen #(.BASE_CYCLES(1)) u_output_line_mux_pulse_gen (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.exposure_window_level(win), .exposure_length_cycles(24'h000004),
		.trigger_passthrough(pass), .trigger_late_copy(late), .strobe_one(s1),
		.strobe_two(s2), .in_line_one(in1), .in_line_two(in1),
		.line_electrical_kind(8'h40), .in_line_one_level(lv1), .in_line_two_level(lv2),
		.out_line_one(o1), .out_line_one_oe(oe1), .out_line_two(o2), .out_line_two_oe(oe2),
		.pulse_trigger(ptrig));
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	// one apb transfer; the leading edge keeps back-to-back calls apart
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd      = prdata;
		perr    = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// counts cycles with the chosen output high
	task automatic count_high(input logic pick_gen, input int n);
		c = 0;
		repeat (n)
		begin
			@(posedge pclk);
			if ((pick_gen ? ptrig : o1) === 1'b1)
				c++;
		end
	endtask : count_high
	task automatic complete_run;
		if (err_count == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : complete_run
	// watchdog: the whole sequence needs well under 2000 cycles
	initial
	begin
		repeat (5000) @(posedge pclk);
		err_count++;
		complete_run();
	end
	initial
	begin
		{presetn, psel, penable, pwrite, in1} = 5'h0;
		paddr  = 8'h00;
		pwdata = 32'h0;
		lvl    = 5'h0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h14, 32'h0);
		check("repeat reset", rd, 32'h0000c350);
		apb(1'b0, 8'h30, 32'h0);
		check("unmapped err", {31'h0, perr}, 32'h1);
		check("undriven oe", {oe1, oe2}, 2'h2);
		// input inversion seen on the level output; source field dropped on inputs
		apb(1'b1, 8'h04, 32'h71);
		in1 <= 1'b1;
		apb(1'b0, 8'h04, 32'h0);
		check("input cfg", rd, 32'h1);
		repeat (3) @(posedge pclk);
		check("input invert", lv1, 1'b0);
		check("input two plain", lv2, 1'b1);
		apb(1'b1, 8'h00, 32'h2);
		apb(1'b1, 8'h04, 32'h1);
		repeat (2) @(posedge pclk);
		check("off inverted", o1, 1'b1);
		// level sources follow their input, status reads the level
		for (int i = 0; i < 5; i++)
		begin
			apb(1'b1, 8'h04, {24'h0, codes[i], 4'h0});
			lvl <= 5'h01 << i;
			repeat (3) @(posedge pclk);
			check("level src high", o1, 1'b1);
			apb(1'b0, 8'h08, 32'h0);
			check("status", rd[5:0], 6'h03);
			lvl <= 5'h00;
			repeat (3) @(posedge pclk);
			check("level src low", o1, 1'b0);
		end
		// begin, finish and midpoint each give exactly one pulse
		for (int k = 1; k < 4; k++)
		begin
			apb(1'b1, 8'h04, {24'h0, k[3:0], 4'h0});
			lvl <= 5'h01;
			count_high(1'b0, 10);
			n = c;
			lvl <= 5'h00;
			count_high(1'b0, 10);
			check("exposure pulses", c + n, 32'h1);
		end
		// burst of 3: high 2, period 4, unit 1 cycle
		apb(1'b1, 8'h04, 32'h70);
		apb(1'b1, 8'h10, 32'h2);
		apb(1'b1, 8'h14, 32'h4);
		apb(1'b1, 8'h18, 32'h3);
		apb(1'b1, 8'h0c, 32'h3);
		count_high(1'b0, 40);
		check("burst high cycles", c, 32'h6);
		apb(1'b0, 8'h1c, 32'h0);
		check("burst done", {31'h0, rd[1]}, 32'h1);
		// continuous, unit 10 cycles: high 1 unit of a 2 unit period
		apb(1'b1, 8'h0c, 32'h0);
		apb(1'b1, 8'h10, 32'h1);
		apb(1'b1, 8'h14, 32'h2);
		apb(1'b1, 8'h0c, 32'h11);
		c = 0;
		while (ptrig !== 1'b1 && c < 50)
		begin
			@(posedge pclk);
			c++;
		end
		count_high(1'b1, 40);
		check("continuous high", c, 32'h14);
		// second output line: passthrough, finish pulse, status; the pulse source is written but never checked
		apb(1'b1, 8'h00, 32'h3);
		apb(1'b1, 8'h04, 32'h70);
		apb(1'b1, 8'h04, 32'h50);
		lvl <= 5'h03;
		repeat (3) @(posedge pclk);
		check("line two pass", o2, 1'b1);
		apb(1'b1, 8'h04, 32'h20);
		lvl <= 5'h00;
		repeat (3) @(posedge pclk);
		check("line two finish", o2, 1'b1);
		@(posedge pclk);
		check("finish one cycle", o2, 1'b0);
		apb(1'b0, 8'h08, 32'h0);
		check("line two status", rd[5:0], 6'h12);
		apb(1'b1, 8'h0c, 32'h0);
		repeat (2) @(posedge pclk);
		check("disabled rests", ptrig, 1'b0);
		complete_run();
	end
endmodule : output_line_mux_pulse_gen_test
